//--- hdl/rss_pkg.sv
/*
 Package for the radio state sequencer: states, commands, timing figures
 and the carrier structs. Assumes a single system clock at CLK_HZ.
*/
package rss_pkg;
	localparam int CLK_HZ = 10_000_000;
	localparam int NS_PER_CYC = 1_000_000_000 / CLK_HZ;
	// Times as printed, in their own units
	localparam int T_POWERON_US = 500;
	localparam int T_SLEEP_WAKE_US = 1;
	localparam int T_DEEP_WAKE_US = 500;
	localparam int T_RESET_US = 1;
	localparam int T_TRX_TYP_US = 90;
	localparam int T_TRX_MAX_US = 200;
	localparam int T_REACT_NS = 200;
	localparam int T_PA_DELAY_US = 4;
	localparam int T_RAMPDOWN_US = 33;
	localparam int T_PLL_MIN_US = 10;
	localparam int T_PLL_MAX_US = 100;
	localparam int T_RX_FRAME_END_EVENT_MAX_US = 100;
	// Cycle counts: least times round up, longest round down
	localparam int CYC_POWERON = T_POWERON_US * (CLK_HZ / 1_000_000);
	localparam int CYC_SLEEP_WAKE = T_SLEEP_WAKE_US * (CLK_HZ / 1_000_000);
	localparam int CYC_DEEP_WAKE = T_DEEP_WAKE_US * (CLK_HZ / 1_000_000);
	localparam int CYC_RESET = T_RESET_US * (CLK_HZ / 1_000_000);
	localparam int CYC_TRX = T_TRX_TYP_US * (CLK_HZ / 1_000_000);
	localparam int CYC_REACT = T_REACT_NS / NS_PER_CYC;
	localparam int CYC_PA_DELAY = T_PA_DELAY_US * (CLK_HZ / 1_000_000);
	localparam int CYC_RAMPDOWN = T_RAMPDOWN_US * (CLK_HZ / 1_000_000) - 1;
	localparam int CYC_PLL = T_PLL_MIN_US * (CLK_HZ / 1_000_000);
	localparam int CYC_RX_FRAME_END_EVENT_MAX = T_RX_FRAME_END_EVENT_MAX_US * (CLK_HZ / 1_000_000);
	localparam int CNT_W = 13;
	localparam logic [2:0] CLOCK_OUT_PIN_OFF = 3'h0;
	localparam logic [2:0] CLOCK_OUT_PIN_RESET_SEL = 3'h1;
	localparam logic [1:0] PA_RAMP_RESET = 2'h3;

	typedef enum logic [2:0] {
		RSS_CMD_NOP, RSS_CMD_SLEEP, RSS_CMD_DEEP_SLEEP, RSS_CMD_IDLE,
		RSS_CMD_TXPREP, RSS_CMD_TX, RSS_CMD_RX
	} rss_cmd_e;

	typedef enum logic [3:0] {
		RSS_ST_POWERUP, RSS_ST_RESET, RSS_ST_SLEEP, RSS_ST_DEEP_SLEEP,
		RSS_ST_WAKING, RSS_ST_IDLE, RSS_ST_TO_TXPREP, RSS_ST_TO_RX,
		RSS_ST_TXPREP, RSS_ST_RX, RSS_ST_TX, RSS_ST_RAMPDOWN
	} rss_state_e;

	typedef struct packed {
		logic valid;
		rss_cmd_e cmd;
	} rss_cmd_s;

	typedef struct packed {
		logic wake;
		logic radio_ready;
		logic rx_frame_end;
		logic pa_ramp_start;
		logic pll_locked;
	} rss_event_s;
endpackage

//--- hdl/rss_sequencer.sv
/*
 Radio state sequencer: operating states, transition timing, events and
 the clock output divider. Assumes commands arrive as one-cycle strobes
 issued at the last rising serial clock edge of the value byte, already
 on clk_sys. Frame-end and pin inputs are asynchronous and synchronised.
*/
`timescale 1ns/1ps
module rss_sequencer
	import rss_pkg::*;
#(
	parameter int POWERON_CYC = CYC_POWERON,
	parameter int DEEP_WAKE_CYC = CYC_DEEP_WAKE,
	parameter int REF_HZ = 26_000_000
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic reset_pin_low,
	input wire rss_cmd_s cmd_in,
	input wire logic [2:0] clock_out_freq_select,
	input wire logic [1:0] pa_ramp_time_setting,
	input wire logic channel_change,
	input wire logic rx_frame_end_in,
	input wire logic tx_frame_end_in,
	output rss_state_e state,
	output rss_event_s events,
	output logic clock_out_pin
);
	if (POWERON_CYC < 1 || POWERON_CYC >= 2 ** CNT_W ||
	    DEEP_WAKE_CYC < 1 || DEEP_WAKE_CYC >= 2 ** CNT_W) begin : g_bad_wake
		$error("Wake counts out of counter range");
	end

	// Two-stage synchronisers for pin and async inputs
	logic [2:0] sync1;
	logic [2:0] sync2;
	logic [2:0] next_sync1;
	logic rst_pin_low_s;
	logic rx_frame_end_event_s;
	logic tx_frame_end_event_s;
	always_comb begin
		next_sync1 = {reset_pin_low, rx_frame_end_in, tx_frame_end_in};
	end
	always_ff @(posedge clk_sys) begin
		// Idle levels: pin high, frame ends low, so no false edge
		if (sys_rst) begin
			sync1 <= 3'h4;
			sync2 <= 3'h4;
		end else begin
			sync1 <= next_sync1;
			sync2 <= sync1;
		end
	end
	assign rst_pin_low_s = ~sync2[2];

	// Frame ends are edge-detected so a long level counts once
	logic rx_frame_end_event_d;
	logic tx_frame_end_event_d;
	logic next_rx_frame_end_event_d;
	logic next_tx_frame_end_event_d;
	always_comb begin
		next_rx_frame_end_event_d = sync2[1];
		next_tx_frame_end_event_d = sync2[0];
	end
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			rx_frame_end_event_d <= 1'b0;
			tx_frame_end_event_d <= 1'b0;
		end else begin
			rx_frame_end_event_d <= next_rx_frame_end_event_d;
			tx_frame_end_event_d <= next_tx_frame_end_event_d;
		end
	end
	assign rx_frame_end_event_s = sync2[1] & ~rx_frame_end_event_d;
	assign tx_frame_end_event_s = sync2[0] & ~tx_frame_end_event_d;

	// Main state machine
	rss_state_e next_state;
	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] next_cnt;
	logic [CNT_W-1:0] pa_cnt;
	logic [CNT_W-1:0] next_pa_cnt;
	logic [CNT_W-1:0] pll_cnt;
	logic [CNT_W-1:0] next_pll_cnt;
	rss_event_s next_events;
	logic is_cmd;
	rss_cmd_e cmd;
	assign is_cmd = cmd_in.valid;
	assign cmd = cmd_in.cmd;

	function automatic logic [CNT_W-1:0] cyc(input int n);
		cyc = n[CNT_W-1:0];
	endfunction

	always_comb begin
		next_state = state;
		next_cnt = (cnt != '0) ? cnt - 1'b1 : cnt;
		next_pa_cnt = (pa_cnt != '0) ? pa_cnt - 1'b1 : pa_cnt;
		next_pll_cnt = (pll_cnt != '0) ? pll_cnt - 1'b1 : pll_cnt;
		next_events = '0;
		if (rst_pin_low_s) begin
			next_state = RSS_ST_RESET;
			next_cnt = cyc(CYC_RESET);
		end else begin
			case (state)
			RSS_ST_POWERUP: begin
				if (cnt == '0) begin
					next_state = RSS_ST_IDLE;
					next_events.wake = 1'b1;
				end
			end
			RSS_ST_RESET: begin
				if (cnt == '0)
					next_state = RSS_ST_IDLE;
			end
			RSS_ST_SLEEP: begin
				if (is_cmd && cmd == RSS_CMD_IDLE) begin
					next_state = RSS_ST_WAKING;
					next_cnt = cyc(CYC_SLEEP_WAKE - 1);
				end
			end
			RSS_ST_DEEP_SLEEP: begin
				if (is_cmd && cmd == RSS_CMD_IDLE) begin
					next_state = RSS_ST_WAKING;
					next_cnt = cyc(DEEP_WAKE_CYC - 1);
				end
			end
			RSS_ST_WAKING: begin
				if (cnt == '0) begin
					next_state = RSS_ST_IDLE;
					next_events.wake = 1'b1;
				end
			end
			RSS_ST_IDLE: begin
				// timers load in the strobe cycle
				if (is_cmd) begin
					case (cmd)
					RSS_CMD_SLEEP: next_state = RSS_ST_SLEEP;
					RSS_CMD_DEEP_SLEEP: next_state = RSS_ST_DEEP_SLEEP;
					RSS_CMD_TXPREP: begin
						next_state = RSS_ST_TO_TXPREP;
						next_cnt = cyc(CYC_TRX - 1);
					end
					RSS_CMD_RX: begin
						next_state = RSS_ST_TO_RX;
						next_cnt = cyc(CYC_TRX - 1);
					end
					default: next_state = state;
					endcase
				end
			end
			RSS_ST_TO_TXPREP: begin
				if (cnt == '0) begin
					next_state = RSS_ST_TXPREP;
					next_events.radio_ready = 1'b1;
				end
			end
			RSS_ST_TO_RX: begin
				if (cnt == '0)
					next_state = RSS_ST_RX;
			end
			RSS_ST_TXPREP: begin
				if (channel_change)
					next_pll_cnt = cyc(CYC_PLL);
				else if (pll_cnt == 13'h0001)
					next_events.pll_locked = 1'b1;
				if (is_cmd) begin
					case (cmd)
					RSS_CMD_TX: begin
						next_state = RSS_ST_TX;
						next_pa_cnt = cyc(CYC_PA_DELAY);
					end
					RSS_CMD_RX: next_state = RSS_ST_RX;
					RSS_CMD_IDLE: next_state = RSS_ST_IDLE;
					default: next_state = state;
					endcase
				end
			end
			RSS_ST_RX: begin
				if (rx_frame_end_event_s) begin
					next_state = RSS_ST_TXPREP;
					next_events.rx_frame_end = 1'b1;
				end else if (is_cmd && cmd == RSS_CMD_TXPREP)
					next_state = RSS_ST_TXPREP;
				else if (is_cmd && cmd == RSS_CMD_IDLE)
					next_state = RSS_ST_IDLE;
			end
			RSS_ST_TX: begin
				if (pa_cnt == 13'h0001)
					next_events.pa_ramp_start = 1'b1;
				if (tx_frame_end_event_s)
					next_state = RSS_ST_TXPREP;
				else if (is_cmd && cmd == RSS_CMD_IDLE)
					next_state = RSS_ST_IDLE;
				else if (is_cmd && cmd == RSS_CMD_TXPREP) begin
					next_state = RSS_ST_RAMPDOWN;
					next_cnt = (pa_ramp_time_setting == PA_RAMP_RESET) ?
						cyc(CYC_RAMPDOWN - 1) : cyc(CYC_REACT);
				end
			end
			RSS_ST_RAMPDOWN: begin
				if (cnt == '0)
					next_state = RSS_ST_TXPREP;
			end
			default: next_state = RSS_ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			state <= RSS_ST_POWERUP;
			cnt <= cyc(POWERON_CYC - 1);
			pa_cnt <= '0;
			pll_cnt <= '0;
			events <= '0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			pa_cnt <= next_pa_cnt;
			pll_cnt <= next_pll_cnt;
			events <= next_events;
		end
	end

	// clock output divider
	// Limitation: rates model the reference at REF_HZ as a tick
	// accumulator; rates above half clk_sys are capped at half clk_sys.
	logic [31:0] acc;
	logic [31:0] next_acc;
	logic [31:0] step;
	logic next_clock_out_pin;
	logic clk_off;
	always_comb begin
		case (clock_out_freq_select)
		3'h1: step = 32'(REF_HZ);
		3'h2: step = 32'(32_000_000);
		3'h3: step = 32'(16_000_000);
		3'h4: step = 32'(8_000_000);
		3'h5: step = 32'(4_000_000);
		3'h6: step = 32'(2_000_000);
		3'h7: step = 32'(1_000_000);
		default: step = 32'h0;
		endcase
		clk_off = (clock_out_freq_select == CLOCK_OUT_PIN_OFF) ||
			(state == RSS_ST_SLEEP) || (state == RSS_ST_DEEP_SLEEP);
		next_acc = acc + (step << 1);
		next_clock_out_pin = clock_out_pin;
		if (clk_off) begin
			next_acc = '0;
			next_clock_out_pin = 1'b0;
		end else if ((step << 1) >= 32'(CLK_HZ)) begin
			// Too fast for clk_sys; keeps acc from growing and wrapping
			next_acc = '0;
			next_clock_out_pin = ~clock_out_pin;
		end else if (next_acc >= 32'(CLK_HZ)) begin
			next_acc = next_acc - 32'(CLK_HZ);
			next_clock_out_pin = ~clock_out_pin;
		end
	end
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			acc <= '0;
			clock_out_pin <= 1'b0;
		end else begin
			acc <= next_acc;
			clock_out_pin <= next_clock_out_pin;
		end
	end
endmodule

//--- verification/rss_sequencer_properties.sv
/*
 Checker for the radio state sequencer, bound to its top ports.
 Assumes the one clock clk_sys and the synchronous reset sys_rst.
*/
`timescale 1ns/1ps
module rss_sequencer_chk
	import rss_pkg::*;
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire rss_cmd_s cmd_in,
	input wire rss_state_e state,
	input wire rss_event_s events
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	logic [7:0] tx_cnt;
	logic [7:0] next_tx_cnt;
	// Saturates, so a long transmit never wraps onto the ramp mark
	always_comb begin
		next_tx_cnt = (state != RSS_ST_TX) ? 8'h00 :
			tx_cnt + {7'h00, tx_cnt != 8'hFF};
	end
	always_ff @(posedge clk_sys) begin
		tx_cnt <= next_tx_cnt;
	end
	sequence s_cmd(st, c);
		state == st && cmd_in.valid && cmd_in.cmd == c;
	endsequence
	property p_next(st, c, nx);
		s_cmd(st, c) |=> state == nx;
	endproperty
	AST_PREP_TO_TX:
		assert property (p_next(RSS_ST_TXPREP, RSS_CMD_TX, RSS_ST_TX))
		else $error("transmit not entered");
	AST_PREP_TO_RX:
		assert property (p_next(RSS_ST_TXPREP, RSS_CMD_RX, RSS_ST_RX))
		else $error("receive not entered");
	AST_PREP_TO_IDLE:
		assert property (p_next(RSS_ST_TXPREP, RSS_CMD_IDLE, RSS_ST_IDLE))
		else $error("idle not entered from prepare");
	AST_RX_TO_IDLE:
		assert property (p_next(RSS_ST_RX, RSS_CMD_IDLE, RSS_ST_IDLE))
		else $error("idle not entered from receive");
	AST_TX_TO_IDLE:
		assert property (p_next(RSS_ST_TX, RSS_CMD_IDLE, RSS_ST_IDLE))
		else $error("idle not entered from transmit");
	AST_UNDEF_KEEPS:
		assert property (p_next(RSS_ST_IDLE, RSS_CMD_TX, RSS_ST_IDLE))
		else $error("undefined command moved the state");
	AST_PA_RAMP_DELAY:
		assert property (events.pa_ramp_start == (state == RSS_ST_TX &&
			tx_cnt == 8'(CYC_PA_DELAY)))
		else $error("ramp start off its delay");
	AST_RX_TO_PREP:
		assert property (p_next(RSS_ST_RX, RSS_CMD_TXPREP, RSS_ST_TXPREP))
		else $error("prepare not entered from receive");
	AST_WAKE_IN_IDLE:
		assert property (events.wake |-> state == RSS_ST_IDLE)
		else $error("wake outside idle");
	AST_READY_ON_PREP:
		assert property (events.radio_ready |-> state == RSS_ST_TXPREP &&
			$past(state) == RSS_ST_TO_TXPREP) else $error("ready misplaced");
endmodule
bind rss_sequencer rss_sequencer_chk i_chk (.clk_sys, .sys_rst, .cmd_in,
	.state, .events);

//--- verification/rss_host_model.sv
/*
 Host model: issues state commands as one-cycle strobes.
 Assumes the bench calls issue() while clk_sys runs.
*/
`timescale 1ns/1ps
module rss_host_model
	import rss_pkg::*;
(
	input wire logic clk_sys,
	output rss_cmd_s cmd_in
);
	initial cmd_in = '0;
	task automatic issue(input rss_cmd_e c);
		@(negedge clk_sys);
		cmd_in = '{valid: 1'b1, cmd: c};
		@(negedge clk_sys);
		cmd_in = '0;
	endtask
endmodule

//--- verification/rss_sequencer_tb_top.sv
/*
 Bench for the radio state sequencer: pins driven at the falling edge,
 commands through the host model. Assumes shortened wake counts.
*/
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin fail_count++; \
	$display("unexpected at %0t: %0h vs %0h", $time, (a), (e)); end end
module rss_sequencer_tb_top
	import rss_pkg::*;
;
	localparam int WAKE_CYC = 20;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic reset_pin_low = 1'b1;
	rss_cmd_s cmd_in;
	logic [2:0] clock_out_freq_select = 3'h4;
	logic [1:0] pa_ramp_time_setting = 2'h3;
	logic rx_frame_end_in = 1'b0;
	logic tx_frame_end_in = 1'b0;
	logic channel_change = 1'b0;
	rss_state_e state;
	rss_event_s events;
	logic clock_out_pin;
	int fail_count = 0;
	int n_compared = 0;
	int n;
	rss_sequencer #(.POWERON_CYC(WAKE_CYC), .DEEP_WAKE_CYC(WAKE_CYC)) i_dut (
		.clk_sys, .sys_rst, .reset_pin_low, .cmd_in, .clock_out_freq_select,
		.pa_ramp_time_setting, .channel_change, .rx_frame_end_in,
		.tx_frame_end_in, .state, .events, .clock_out_pin);
	rss_host_model i_host (.clk_sys, .cmd_in);
	initial begin
		forever #50 clk_sys = ~clk_sys;
	end
	task automatic wait_st(input rss_state_e st, input int lim);
		n = 0;
		do begin
			@(negedge clk_sys);
			n++;
		end while (state !== st && n < lim);
	endtask
	task automatic go(input rss_cmd_e c, input rss_state_e st, input int lim);
		i_host.issue(c);
		wait_st(st, lim);
	endtask
	task automatic t_power();
		wait_st(RSS_ST_IDLE, 100);
		`CHK(n <= WAKE_CYC + 1, 1'b1)
		`CHK(events.wake, 1'b1)
	endtask
	task automatic t_chain();
		go(RSS_CMD_TXPREP, RSS_ST_TXPREP, 2000);
		`CHK(n, 900)
		`CHK(events.radio_ready, 1'b1)
		channel_change = 1'b1;
		@(negedge clk_sys);
		channel_change = 1'b0;
		n = 1;
		do begin
			@(negedge clk_sys);
			n++;
		end while (events.pll_locked !== 1'b1 && n < 200);
		`CHK(n - 1, CYC_PLL)
		go(RSS_CMD_TX, RSS_ST_TX, 9);
		`CHK(n, 1)
		n = 0;
		do begin
			@(negedge clk_sys);
			n++;
		end while (events.pa_ramp_start !== 1'b1 && n < 99);
		// One edge of the delay already went by inside go
		`CHK(n + 1, CYC_PA_DELAY)
		tx_frame_end_in = 1'b1;
		wait_st(RSS_ST_TXPREP, 20);
		`CHK(n <= 6, 1'b1)
		tx_frame_end_in = 1'b0;
		go(RSS_CMD_RX, RSS_ST_RX, 9);
		`CHK(n, 1)
		rx_frame_end_in = 1'b1;
		wait_st(RSS_ST_TXPREP, 20);
		`CHK(n <= 6, 1'b1)
		`CHK(events.rx_frame_end, 1'b1)
		rx_frame_end_in = 1'b0;
		go(RSS_CMD_IDLE, RSS_ST_IDLE, 9);
		`CHK(n, 1)
	endtask
	task automatic t_rx();
		i_host.issue(RSS_CMD_TX);
		repeat (3) @(negedge clk_sys);
		`CHK(state, RSS_ST_IDLE)
		go(RSS_CMD_RX, RSS_ST_RX, 2000);
		`CHK(n, 900)
		go(RSS_CMD_IDLE, RSS_ST_IDLE, 9);
		`CHK(n, 1)
	endtask
	task automatic t_tx_exit(input rss_cmd_e c, input rss_state_e st);
		// Past the ramp start, so the exit is from steady transmit
		go(RSS_CMD_TXPREP, RSS_ST_TXPREP, 2000);
		go(RSS_CMD_TX, RSS_ST_TX, 9);
		repeat (45) @(negedge clk_sys);
		go(c, st, 400);
		`CHK(state, st)
		`CHK(n <= ((c == RSS_CMD_IDLE) ? 1 :
			T_RAMPDOWN_US * (CLK_HZ / 1_000_000)), 1'b1)
		go(RSS_CMD_IDLE, RSS_ST_IDLE, 9);
	endtask
	task automatic t_wake(input rss_cmd_e c, input rss_state_e s, input int lim);
		i_host.issue(c);
		repeat (3) @(negedge clk_sys);
		`CHK(state, s)
		go(RSS_CMD_IDLE, RSS_ST_IDLE, 99);
		`CHK(n <= lim, 1'b1)
		`CHK(events.wake, 1'b1)
	endtask
	task automatic t_pin();
		logic last;
		int toggles = 0;
		reset_pin_low = 1'b0;
		repeat (5) @(negedge clk_sys);
		`CHK(state, RSS_ST_RESET)
		clock_out_freq_select = 3'h0;
		reset_pin_low = 1'b1;
		wait_st(RSS_ST_IDLE, 40);
		`CHK(n <= 14, 1'b1)
		`CHK(clock_out_pin, 1'b0)
		// 4 MHz select: two toggles per output period
		clock_out_freq_select = 3'h5;
		last = clock_out_pin;
		repeat (50) begin
			@(negedge clk_sys);
			toggles += (clock_out_pin != last);
			last = clock_out_pin;
		end
		`CHK(toggles, 2 * 4 * 50 / (CLK_HZ / 1_000_000))
	endtask
	task automatic summarize();
		$display("compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		repeat (3) @(negedge clk_sys);
		sys_rst = 1'b0;
		t_power();
		t_chain();
		t_rx();
		t_tx_exit(RSS_CMD_IDLE, RSS_ST_IDLE);
		t_tx_exit(RSS_CMD_TXPREP, RSS_ST_TXPREP);
		t_wake(RSS_CMD_SLEEP, RSS_ST_SLEEP, 10);
		t_wake(RSS_CMD_DEEP_SLEEP, RSS_ST_DEEP_SLEEP, WAKE_CYC);
		t_pin();
		summarize();
	end
	// Whole run needs some 4300 cycles
	initial begin
		repeat (20000) @(negedge clk_sys);
		fail_count++;
		summarize();
	end
endmodule
